// ---- hdl/timer_core.sv ----
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_core
  import timer_pkg::*;
#(
  parameter bit WIDE_CAPABLE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`NUM_CHANNELS-1:0] chanInPins,
  output logic [`NUM_CHANNELS-1:0] chanOutPins,
  output logic irq
);
  tick_if tk();
  logic enable_reg;
  logic wideReq_reg;
  logic [`CHCFG_WIDTH*`NUM_CHANNELS-1:0] chanCfg_reg;
  logic [`STAT_WIDTH-1:0] status_reg;
  logic [`STAT_WIDTH-1:0] mask_reg;
  logic [31:0] count_reg;
  logic [15:0] divider_reg;
  logic [31:0] period_reg;
  logic [`NUM_CHANNELS-1:0] sync1_reg;
  logic [`NUM_CHANNELS-1:0] sync2_reg;
  logic [`NUM_CHANNELS-1:0] sync3_reg;
  logic [`NUM_CHANNELS-1:0] capture;
  logic [`NUM_CHANNELS-1:0] hit;
  logic [`NUM_CHANNELS-1:0] hitPrev_reg;
  logic [`NUM_CHANNELS-1:0] chWrite;
  logic [`NUM_CHANNELS-1:0] chOut;
  logic [31:0] chData [`NUM_CHANNELS];
  logic [31:0] widthMask;
  logic wide;
  logic run;
  logic wrStrobe;
  logic rdStrobe;
  logic addrValid;
  logic [`STAT_WIDTH-1:0] events;

  function automatic logic isAddr(input logic [11:0] a, input logic [11:0] target);
    isAddr = (a == target);
  endfunction : isAddr

  assign wide = WIDE_CAPABLE && wideReq_reg;
  assign widthMask = wide ? 32'hffffffff : 32'h0000ffff;
  assign run = enable_reg && ((period_reg & widthMask) != 32'h00000000);
  assign tk.overflow = tk.tick && ((count_reg & widthMask) >= (period_reg & widthMask));
  assign wrStrobe = psel && penable && pwrite;
  assign rdStrobe = psel && !penable && !pwrite;
  assign addrValid = isAddr(paddr, `ADDR_CONTROL) || isAddr(paddr, `ADDR_CHANNEL_CFG) ||
    isAddr(paddr, `ADDR_STATUS) || isAddr(paddr, `ADDR_MASK) || isAddr(paddr, `ADDR_COUNTER_VALUE) ||
    isAddr(paddr, `ADDR_PRESCALE_DIVIDER) || isAddr(paddr, `ADDR_COUNT_PERIOD) ||
    isAddr(paddr, `ADDR_CH1_DATA) || isAddr(paddr, `ADDR_CH2_DATA) || isAddr(paddr, `ADDR_CH3_DATA);
  assign chWrite[0] = wrStrobe && isAddr(paddr, `ADDR_CH1_DATA);
  assign chWrite[1] = wrStrobe && isAddr(paddr, `ADDR_CH2_DATA);
  assign chWrite[2] = wrStrobe && isAddr(paddr, `ADDR_CH3_DATA);

  timer_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(run),
    .divider(divider_reg),
    .tk(tk)
  );

  // Pins pass three flops and a rising edge counts only once the last two agree on the high level.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= chanInPins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  logic [`NUM_CHANNELS-1:0] settled_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      settled_reg <= 3'h0;
    end else begin
      settled_reg <= (sync2_reg & sync3_reg) | (settled_reg & (sync2_reg | sync3_reg));
    end
  end
  assign capture = (sync2_reg & sync3_reg) & ~settled_reg;

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_chan
      timer_channel u_channel (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cfg(chanCfg_reg[ch*`CHCFG_WIDTH +: `CHCFG_WIDTH]),
        .wide(wide),
        .count(count_reg),
        .update(tk.overflow),
        .capture(capture[ch]),
        .write(chWrite[ch]),
        .wdata(pwdata),
        .data(chData[ch]),
        .compareHit(hit[ch]),
        .chanOut(chOut[ch])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 32'h00000000;
    end else if (wrStrobe && isAddr(paddr, `ADDR_COUNTER_VALUE)) begin
      count_reg <= pwdata & widthMask;
    end else if (tk.overflow) begin
      count_reg <= 32'h00000000;
    end else if (tk.tick) begin
      count_reg <= (count_reg + 32'h00000001) & widthMask;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= 1'b0;
      wideReq_reg <= 1'b0;
      chanCfg_reg <= 12'h000;
      mask_reg <= 4'h0;
      divider_reg <= 16'h0000;
      period_reg <= 32'h00000000;
    end else if (wrStrobe) begin
      if (isAddr(paddr, `ADDR_CONTROL)) begin
        enable_reg <= pwdata[`CTRL_ENABLE_BIT];
        wideReq_reg <= pwdata[`CTRL_WIDE_BIT];
      end
      if (isAddr(paddr, `ADDR_CHANNEL_CFG)) begin
        chanCfg_reg <= pwdata[`CHCFG_WIDTH*`NUM_CHANNELS-1:0];
      end
      if (isAddr(paddr, `ADDR_MASK)) begin
        mask_reg <= pwdata[`STAT_WIDTH-1:0];
      end
      if (isAddr(paddr, `ADDR_PRESCALE_DIVIDER)) begin
        divider_reg <= pwdata[15:0];
      end
      if (isAddr(paddr, `ADDR_COUNT_PERIOD)) begin
        period_reg <= WIDE_CAPABLE ? pwdata : {16'h0000, pwdata[15:0]};
      end
    end
  end

  // A match raises its flag once per arrival rather than for every cycle the counter sits on it.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hitPrev_reg <= 3'h0;
    end else begin
      hitPrev_reg <= hit;
    end
  end

  always_comb begin
    events = {hit & ~hitPrev_reg, 1'b0};
    events[`STAT_OVF_BIT] = tk.overflow;
  end

  // A new event in the same cycle as a write-one-to-clear keeps its flag set.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= 4'h0;
    end else if (wrStrobe && isAddr(paddr, `ADDR_STATUS)) begin
      status_reg <= (status_reg & ~pwdata[`STAT_WIDTH-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
      chanOutPins <= 3'h0;
    end else begin
      irq <= |(status_reg & mask_reg);
      chanOutPins <= chOut;
    end
  end

  // Read data is latched in the setup cycle, so the access phase completes at once with stable data.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (rdStrobe) begin
      case (paddr)
        `ADDR_CONTROL: prdata <= {30'h00000000, wideReq_reg, enable_reg};
        `ADDR_CHANNEL_CFG: prdata <= {20'h00000, chanCfg_reg};
        `ADDR_STATUS: prdata <= {28'h0000000, status_reg};
        `ADDR_MASK: prdata <= {28'h0000000, mask_reg};
        `ADDR_COUNTER_VALUE: prdata <= count_reg & widthMask;
        `ADDR_PRESCALE_DIVIDER: prdata <= {16'h0000, divider_reg};
        `ADDR_COUNT_PERIOD: prdata <= period_reg & widthMask;
        `ADDR_CH1_DATA: prdata <= chData[0];
        `ADDR_CH2_DATA: prdata <= chData[1];
        `ADDR_CH3_DATA: prdata <= chData[2];
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrValid;
    end
  end
endmodule : timer_core
`default_nettype wire

// ---- hdl/timer_defines.svh ----
// Summary of operation
// - The counter is 16 bits wide and widens to 32 bits, upper half in bits 31 to 16, when the wide mode is on.
// - With the wide mode on, the period register is 32 bits wide so the whole counter counts to a 32-bit period.
// - With the wide mode on, every channel data register is 32 bits wide for both capture and compare.
// - The counter ticks once every divider-plus-one timer clocks, so a divider of zero ticks on every clock.
// - A written divider takes effect only at the next overflow event.
// - The counter runs from zero up to the period value, and reaching it makes an overflow and a restart.
// - A period of zero stops the counter entirely.
// - Channel 1 as an input loads its data register with the counter on each channel 1 input event.
// - Channel 3 as an input loads its data register with the counter on each channel 3 input event.
// - Channel 1 as an output compares its data register continuously against the counter.
// - Channel 2 as an output compares its data register against the running counter.
// - Channel 3 as an output compares its data register against the running counter.
// - Each channel has a compare buffer enable; off applies a write at once, on holds it until the next overflow.
// - Each output channel drives its output pin from the compare result shaped by its output mode.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
`define ADDR_CONTROL 12'h000
`define ADDR_CHANNEL_CFG 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_MASK 12'h00c
`define ADDR_COUNTER_VALUE 12'h010
`define ADDR_PRESCALE_DIVIDER 12'h014
`define ADDR_COUNT_PERIOD 12'h018
`define ADDR_CH1_DATA 12'h01c
`define ADDR_CH2_DATA 12'h020
`define ADDR_CH3_DATA 12'h024
`define CTRL_ENABLE_BIT 0
`define CTRL_WIDE_BIT 1
`define CHCFG_WIDTH 4
`define CHCFG_INPUT_BIT 0
`define CHCFG_BUF_BIT 1
`define CHCFG_MODE_LSB 2
`define STAT_OVF_BIT 0
`define STAT_CH_LSB 1
`define STAT_WIDTH 4
`define NUM_CHANNELS 3
`endif

// ---- hdl/timer_pkg.sv ----
package timer_pkg;
  typedef enum logic [1:0] {
    OUT_FROZEN = 2'b00,
    OUT_SET_ON_MATCH = 2'b01,
    OUT_TOGGLE_ON_MATCH = 2'b10,
    OUT_PWM = 2'b11
  } out_mode_e;
endpackage : timer_pkg

// ---- hdl/tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic tick;
  logic overflow;
  modport source (output tick, input overflow);
  modport sink (input tick, output overflow);
endinterface : tick_if
`default_nettype wire

// ---- hdl/timer_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_prescaler
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [15:0] divider,
  tick_if.source tk
);
  logic [15:0] workDiv_reg;
  logic [15:0] preCount_reg;

  // The working divider only reloads at overflow so a ratio change never splits a period.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      workDiv_reg <= 16'h0000;
    end else if (tk.overflow) begin
      workDiv_reg <= divider;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      preCount_reg <= 16'h0000;
    end else if (!run || tk.overflow || preCount_reg >= workDiv_reg) begin
      preCount_reg <= 16'h0000;
    end else begin
      preCount_reg <= preCount_reg + 16'h0001;
    end
  end

  assign tk.tick = run && (preCount_reg >= workDiv_reg);
endmodule : timer_prescaler
`default_nettype wire

// ---- hdl/timer_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_channel
  import timer_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`CHCFG_WIDTH-1:0] cfg,
  input wire logic wide,
  input wire logic [31:0] count,
  input wire logic update,
  input wire logic capture,
  input wire logic write,
  input wire logic [31:0] wdata,
  output logic [31:0] data,
  output logic compareHit,
  output logic chanOut
);
  logic [31:0] shadow_reg;
  logic [31:0] active_reg;
  logic [31:0] mask;
  logic isInput;
  logic buffered;
  out_mode_e mode;
  logic hitPrev_reg;
  logic arrival;

  assign mask = wide ? 32'hffffffff : 32'h0000ffff;
  assign isInput = cfg[`CHCFG_INPUT_BIT];
  assign buffered = cfg[`CHCFG_BUF_BIT];
  assign mode = out_mode_e'(cfg[`CHCFG_MODE_LSB +: 2]);
  assign data = isInput ? active_reg : shadow_reg;
  assign compareHit = !isInput && ((count & mask) == (active_reg & mask));
  assign arrival = compareHit && !hitPrev_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_reg <= 32'h00000000;
    end else if (write) begin
      shadow_reg <= wdata & mask;
    end
  end

  // A slow prescaler leaves the counter on the match for several clocks, so in the set and toggle modes only the arrival shapes the pin.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hitPrev_reg <= 1'b0;
    end else begin
      hitPrev_reg <= compareHit;
    end
  end

  // Software writes win over a capture in the same cycle so a deliberate preset is not lost.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_reg <= 32'h00000000;
    end else if (write && (isInput || !buffered)) begin
      active_reg <= wdata & mask;
    end else if (isInput && capture) begin
      active_reg <= count & mask;
    end else if (!isInput && buffered && update) begin
      active_reg <= shadow_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chanOut <= 1'b0;
    end else if (isInput) begin
      chanOut <= 1'b0;
    end else begin
      case (mode)
        OUT_FROZEN: chanOut <= chanOut;
        OUT_SET_ON_MATCH: chanOut <= chanOut | arrival;
        OUT_TOGGLE_ON_MATCH: chanOut <= chanOut ^ arrival;
        OUT_PWM: chanOut <= (count & mask) < (active_reg & mask);
        default: chanOut <= 1'b0;
      endcase
    end
  end
endmodule : timer_channel
`default_nettype wire

// ---- tb/timer_core_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module timer_core_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [`NUM_CHANNELS-1:0] chanInPins,
  input wire logic [`NUM_CHANNELS-1:0] chanOutPins,
  input wire logic irq
);
  logic [`STAT_WIDTH-1:0] maskReg;
  logic mapped;
  assign mapped = (paddr <= `ADDR_CH3_DATA) && (paddr[1:0] == 2'b00);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // The mask is mirrored from completed writes, so irq can be judged without seeing status.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      maskReg <= '0;
    end else if (psel && penable && pready && pwrite && paddr == `ADDR_MASK) begin
      maskReg <= pwdata[`STAT_WIDTH-1:0];
    end
  end
  property p_setup_ready; psel && !penable |=> pready; endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_src; pready |-> psel && penable && $past(psel) && !$past(penable); endproperty
  a_ready_src: assert property (p_ready_src) else $error("ready without setup");
  property p_idle; !psel |=> !pready && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("answer while idle");
  property p_err_unmapped; pready && !mapped |-> pslverr; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped without error");
  property p_err_mapped; pslverr |-> pready && !mapped; endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("error on mapped address");
  property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  property p_irq_masked; maskReg == '0 && $past(maskReg) == '0 |-> !irq; endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
endmodule : timer_core_monitor
bind timer_core timer_core_monitor mon (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chanInPins(chanInPins), .chanOutPins(chanOutPins), .irq(irq));
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.svh"
module tb
  import timer_pkg::*;
;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] chanInPins, chanOutPins;
  int error_cnt, samples_checked;
  timer_core #(.WIDE_CAPABLE(1'b1)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chanInPins(chanInPins), .chanOutPins(chanOutPins), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One idle edge ends every transfer, so a following call never drives psel twice in one step.
  // The wait has no limit of its own; a slave that never answers is caught by the watchdog.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr
  // Four reads latch the counter across exactly nine clocks.
  task automatic rate(input string name, input logic [31:0] exp);
    logic [31:0] c0, c1;
    apb(1'b0, `ADDR_COUNTER_VALUE, 32'h0, c0);
    repeat (3) apb(1'b0, `ADDR_COUNTER_VALUE, 32'h0, c1);
    check(name, (c1 - c0) & 32'hff, exp);
  endtask : rate
  task automatic pins(input logic [31:0] d0, input logic [31:0] d1, input logic [31:0] d2, input logic [2:0] exp);
    wr(`ADDR_CH1_DATA, d0); wr(`ADDR_CH2_DATA, d1); wr(`ADDR_CH3_DATA, d2);
    repeat (4) @(posedge ref_clk);
    check("outputs", {29'h0, chanOutPins}, {29'h0, exp});
  endtask : pins
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; chanInPins = 0; reset_n = 0; lastErr = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (logic [11:0] a = 12'h010; a <= 12'h024; a += 12'h004) begin
      apb(1'b0, a, 32'h0, rd); check("reset value", rd, 32'h0);
    end
    apb(1'b0, 12'h040, 32'h0, rd); check("unmapped read", rd, 32'h0);
    check("unmapped error", {31'h0, lastErr}, 32'h1);
    $display("test reset done");
    for (int w = 0; w < 2; w++) begin
      wr(`ADDR_CONTROL, 32'(w) << `CTRL_WIDE_BIT);
      for (logic [11:0] a = 12'h010; a <= 12'h024; a += 12'h004) begin
        if (a != `ADDR_PRESCALE_DIVIDER && (w == 1 || a != `ADDR_COUNT_PERIOD)) begin
          wr(a, 32'h1234abcd); apb(1'b0, a, 32'h0, rd);
          check("width", rd, (w == 1) ? 32'h1234abcd : 32'h0000abcd);
        end
      end
    end
    $display("test width done");
    wr(`ADDR_CONTROL, 32'h0); wr(`ADDR_COUNT_PERIOD, 32'hff); wr(`ADDR_COUNTER_VALUE, 32'h0);
    wr(`ADDR_PRESCALE_DIVIDER, 32'h2); wr(`ADDR_CONTROL, 32'h1);
    rate("ratio before overflow", 32'd9);
    repeat (300) @(posedge ref_clk);
    rate("ratio after overflow", 32'd3);
    apb(1'b0, `ADDR_STATUS, 32'h0, rd); check("overflow flag", rd & 32'h1, 32'h1);
    wr(`ADDR_STATUS, 32'h1); apb(1'b0, `ADDR_STATUS, 32'h0, rd); check("flag clear", rd & 32'h1, 32'h0);
    wr(`ADDR_COUNT_PERIOD, 32'h0); rate("stopped", 32'd0);
    wr(`ADDR_CONTROL, 32'h3);
    wr(`ADDR_COUNTER_VALUE, 32'h0000fffe);
    wr(`ADDR_COUNT_PERIOD, 32'h00020000);
    repeat (30) @(posedge ref_clk);
    apb(1'b0, `ADDR_COUNTER_VALUE, 32'h0, rd);
    check("wide carry", {16'h0000, rd[31:16]}, 32'h1);
    wr(`ADDR_CONTROL, 32'h1);
    wr(`ADDR_COUNT_PERIOD, 32'h0);
    $display("test counting done");
    wr(`ADDR_CHANNEL_CFG, 32'h111);
    for (int i = 0; i < 3; i++) begin
      wr(`ADDR_COUNTER_VALUE, 32'h50 + 32'(i));
      chanInPins[i] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chanInPins[i] <= 1'b0;
      apb(1'b0, `ADDR_CH1_DATA + 12'(4 * i), 32'h0, rd); check("capture", rd, 32'h50 + 32'(i));
    end
    $display("test capture done");
    wr(`ADDR_CHANNEL_CFG, 32'({OUT_PWM, 2'b00, OUT_PWM, 2'b00, OUT_PWM, 2'b00}));
    wr(`ADDR_COUNTER_VALUE, 32'h5);
    pins(32'd10, 32'd3, 32'd10, 3'b101);
    pins(32'd3, 32'd10, 32'd3, 3'b010);
    wr(`ADDR_CHANNEL_CFG, 32'({OUT_PWM, 2'b10, OUT_PWM, 2'b10, OUT_PWM, 2'b10}));
    pins(32'd10, 32'd10, 32'd10, 3'b010);
    wr(`ADDR_COUNT_PERIOD, 32'h2); repeat (20) @(posedge ref_clk);
    wr(`ADDR_CONTROL, 32'h0); wr(`ADDR_COUNTER_VALUE, 32'h5);
    pins(32'd10, 32'd10, 32'd10, 3'b111);
    wr(`ADDR_CHANNEL_CFG, 32'h00000ccc);
    pins(32'd0, 32'd0, 32'd0, 3'b000);
    wr(`ADDR_CHANNEL_CFG, 32'h00000084);
    pins(32'd7, 32'd7, 32'd7, 3'b000);
    wr(`ADDR_STATUS, 32'he);
    wr(`ADDR_COUNTER_VALUE, 32'h7);
    repeat (4) @(posedge ref_clk);
    check("match once", {29'h0, chanOutPins}, 32'h3);
    apb(1'b0, `ADDR_STATUS, 32'h0, rd);
    check("match flags", rd & 32'he, 32'he);
    wr(`ADDR_COUNTER_VALUE, 32'h5);
    wr(`ADDR_COUNTER_VALUE, 32'h7);
    repeat (4) @(posedge ref_clk);
    check("toggle back", {29'h0, chanOutPins}, 32'h1);
    $display("test compare done");
    wr(`ADDR_MASK, 32'h1); repeat (3) @(posedge ref_clk); check("irq on", {31'h0, irq}, 32'h1);
    wr(`ADDR_MASK, 32'h0); repeat (3) @(posedge ref_clk); check("irq masked", {31'h0, irq}, 32'h0);
    wr(`ADDR_MASK, 32'h1); wr(`ADDR_STATUS, 32'h1);
    repeat (3) @(posedge ref_clk); check("irq cleared", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
